/* include/tcc_map.vh */
/*
 register map, field positions, reset values and timing counts of the
 capture-3 and compare-control block. assumes byte-wide register port.
*/
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ----------------------------------------------------------------------
// register offsets (low address bits)
// ----------------------------------------------------------------------
`define TCC_ADDR_W          8
`define TCC_OFS_CAP3_CTL    8'h28
`define TCC_OFS_CAP3_B0     8'h2c
`define TCC_OFS_CAP3_B1     8'h2d
`define TCC_OFS_CAP3_B2     8'h2e
`define TCC_OFS_CAP3_B3     8'h2f
`define TCC_OFS_CMP_CTL0    8'h70
`define TCC_OFS_CMP_CTL1    8'h71
`define TCC_OFS_CMP_CTL2    8'h72
`define TCC_OFS_CMP_CTL3    8'h73

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define TCC_CAP_EDGE_LO     0
`define TCC_CAP_EDGE_HI     1
`define TCC_CAP_NF_BIT      7
`define TCC_CMP_EN_BIT      0
`define TCC_CMP_DBUF_BIT    1
`define TCC_CMP_ACT_LO      4
`define TCC_CMP_ACT_HI      5
`define TCC_CMP_REV_BIT     6

`define TCC_EDGE_NONE       2'h0
`define TCC_EDGE_RISE       2'h1
`define TCC_EDGE_FALL       2'h2
`define TCC_EDGE_BOTH       2'h3

`define TCC_ACT_TOGGLE      2'h0
`define TCC_ACT_SET         2'h1
`define TCC_ACT_CLEAR       2'h2
`define TCC_ACT_NONE        2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TCC_RST_CAP_CTL     8'h00
`define TCC_RST_CMP_CTL     8'h30
`define TCC_RST_BYTE        8'h00

// ----------------------------------------------------------------------
// filter timing, in system clock periods
// ----------------------------------------------------------------------
`define TCC_NF_OFF_CYC      3'h2
`define TCC_NF_ON_CYC       3'h6
`define TCC_CNT_W           3

`endif

/* verilog/tcc_trig_filter.v */
/*
 trigger pin filter and edge detector for the capture-3 input.
 assumes the pin is already synchronous to core_clk_i.
*/
`timescale 1ns/100ps
`include "tcc_map.vh"

module tcc_trig_filter
(
    input  wire       core_clk_i,
    input  wire       rstn_i,
    input  wire       pin_i,
    input  wire       filter_on_i,
    input  wire [1:0] edge_sel_i,
    output reg        trig_o
);

// ----------------------------------------------------------------------
// level must hold a number of cycles before it is taken
// ----------------------------------------------------------------------
reg                    level_ff;
reg  [`TCC_CNT_W-1:0]  cnt_ff;
wire [`TCC_CNT_W-1:0]  need;
wire                   rise;
wire                   fall;

// filter off: level stable two cycles passes; on: six cycles needed
assign need = filter_on_i ? `TCC_NF_ON_CYC : `TCC_NF_OFF_CYC;

always @(posedge core_clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        level_ff <= 1'b0;
        cnt_ff   <= {`TCC_CNT_W{1'b0}};
    end
    else if (pin_i == level_ff)
    begin
        cnt_ff <= {`TCC_CNT_W{1'b0}};
    end
    else if (cnt_ff + 3'h1 >= need)
    begin
        level_ff <= pin_i;
        cnt_ff   <= {`TCC_CNT_W{1'b0}};
    end
    else
    begin
        cnt_ff <= cnt_ff + 3'h1;
    end
end

assign rise = (cnt_ff + 3'h1 >= need) && pin_i && !level_ff;
assign fall = (cnt_ff + 3'h1 >= need) && !pin_i && level_ff;

// ----------------------------------------------------------------------
// edge select
// ----------------------------------------------------------------------
always @(posedge core_clk_i or negedge rstn_i)
begin
    if (!rstn_i)
        trig_o <= 1'b0;
    else
    begin
        case (edge_sel_i)
            `TCC_EDGE_NONE: trig_o <= 1'b0;
            `TCC_EDGE_RISE: trig_o <= rise;
            `TCC_EDGE_FALL: trig_o <= fall;
            `TCC_EDGE_BOTH: trig_o <= rise | fall;
            default:        trig_o <= 1'b0;
        endcase
    end
end

endmodule

/* verilog/tcc_cap_mem.v */
/*
 32-bit capture store, four byte lanes, registered byte read.
 assumes the caller blocks the load while a read is in progress.
*/
`timescale 1ns/100ps
`include "tcc_map.vh"

module tcc_cap_mem
#(
    parameter W = 32
)
(
    input  wire         core_clk_i,
    input  wire         load_i,
    input  wire [W-1:0] value_i,
    input  wire [1:0]   sel_i,
    output reg  [7:0]   byte_o
);

// no reset: content is undefined until the first capture
reg [W-1:0] cap_ff;

always @(posedge core_clk_i)
begin
    if (load_i)
        cap_ff <= value_i;
    byte_o <= cap_ff[sel_i*8 +: 8];
end

endmodule

/* verilog/tcc_capture3_compare.v */
/*
 capture-3 value and control, plus compare control for channels 0..3
 with their output flip-flops. assumes byte registers on a plain port,
 a free-running counter and per-channel compare matches from outside.
*/
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "tcc_map.vh"

// What this block does
// - capture control bits 2..6 read zero
// - capture value: four read-only byte addresses
// - capture value not reset, undefined initially
// - no capture while capture value read
// - action 00 toggle, 01 set, 10 clear
// - compare enable, double buffer, reversal bits
// - edge select none, rise, fall, both
// - filter: off accepts 2 cycles or more, on rejects under 6

module tcc_capture3_compare
#(
    parameter CNT_W = 32,
    parameter NCH   = 4
)
(
    input  wire                   core_clk_i,
    input  wire                   rstn_i,
    input  wire [`TCC_ADDR_W-1:0] addr_i,
    input  wire [7:0]             wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output reg  [7:0]             rdata_o,
    input  wire                   capture_three_trigger_pin_i,
    input  wire [CNT_W-1:0]       counter_i,
    input  wire [NCH-1:0]         compare_match_i,
    output reg  [NCH-1:0]         timer_output_flipflop_o,
    output reg  [NCH-1:0]         compare_channel_enable_o,
    output reg  [NCH-1:0]         compare_double_buffer_enable_o
);

// ----------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------
function is_cap_byte;
    input [`TCC_ADDR_W-1:0] a;
    begin
        is_cap_byte = (a >= `TCC_OFS_CAP3_B0) && (a <= `TCC_OFS_CAP3_B3);
    end
endfunction

function is_cmp;
    input [`TCC_ADDR_W-1:0] a;
    begin
        is_cmp = (a >= `TCC_OFS_CMP_CTL0) && (a <= `TCC_OFS_CMP_CTL3);
    end
endfunction

// ----------------------------------------------------------------------
// capture control
// ----------------------------------------------------------------------
reg  [1:0] capture_three_edge_select_ff;
reg        capture_three_noise_filter_ff;
wire       trig;
wire [7:0] cap_byte;
reg        rd_cap_ff;
reg        rd_other_ff;
reg  [7:0] other_ff;

always @(posedge core_clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        capture_three_edge_select_ff  <= `TCC_EDGE_NONE;
        capture_three_noise_filter_ff <= 1'b0;
    end
    else if (wr_i && addr_i == `TCC_OFS_CAP3_CTL)
    begin
        capture_three_edge_select_ff  <= wdata_i[`TCC_CAP_EDGE_HI:`TCC_CAP_EDGE_LO];
        capture_three_noise_filter_ff <= wdata_i[`TCC_CAP_NF_BIT];
    end
end

tcc_trig_filter u_filt
(
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .pin_i       (capture_three_trigger_pin_i),
    .filter_on_i (capture_three_noise_filter_ff),
    .edge_sel_i  (capture_three_edge_select_ff),
    .trig_o      (trig)
);

// a trigger coinciding with a capture-value byte read strobe is dropped, not deferred
tcc_cap_mem #(.W(CNT_W)) u_cap
(
    .core_clk_i (core_clk_i),
    .load_i     (trig && !(rd_i && is_cap_byte(addr_i))),
    .value_i    (counter_i),
    .sel_i      (addr_i[1:0]),
    .byte_o     (cap_byte)
);

// ----------------------------------------------------------------------
// compare control and output flip-flops
// ----------------------------------------------------------------------
reg [1:0]     act_ff [0:NCH-1];
reg [NCH-1:0] rev_ff;
integer       i;

always @(posedge core_clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        for (i = 0; i < NCH; i = i + 1)
            act_ff[i] <= `TCC_ACT_NONE;
        rev_ff                         <= {NCH{1'b0}};
        compare_channel_enable_o       <= {NCH{1'b0}};
        compare_double_buffer_enable_o <= {NCH{1'b0}};
    end
    else if (wr_i && is_cmp(addr_i))
    begin
        for (i = 0; i < NCH; i = i + 1)
            if (addr_i[1:0] == i[1:0])
            begin
                act_ff[i]                         <= wdata_i[`TCC_CMP_ACT_HI:`TCC_CMP_ACT_LO];
                rev_ff[i]                         <= wdata_i[`TCC_CMP_REV_BIT];
                compare_channel_enable_o[i]       <= wdata_i[`TCC_CMP_EN_BIT];
                compare_double_buffer_enable_o[i] <= wdata_i[`TCC_CMP_DBUF_BIT];
            end
    end
end

always @(posedge core_clk_i or negedge rstn_i)
begin
    if (!rstn_i)
        timer_output_flipflop_o <= {NCH{1'b0}};
    else
    begin
        for (i = 0; i < NCH; i = i + 1)
            if (compare_match_i[i] && compare_channel_enable_o[i] && rev_ff[i])
            begin
                case (act_ff[i])
                    `TCC_ACT_TOGGLE: timer_output_flipflop_o[i] <= ~timer_output_flipflop_o[i];
                    `TCC_ACT_SET:    timer_output_flipflop_o[i] <= 1'b1;
                    `TCC_ACT_CLEAR:  timer_output_flipflop_o[i] <= 1'b0;
                    default:         timer_output_flipflop_o[i] <= timer_output_flipflop_o[i];
                endcase
            end
    end
end

// ----------------------------------------------------------------------
// read path: one cycle latency, unmapped reads return zero
// ----------------------------------------------------------------------
always @(posedge core_clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        rd_cap_ff   <= 1'b0;
        rd_other_ff <= 1'b0;
        other_ff    <= `TCC_RST_BYTE;
    end
    else
    begin
        rd_cap_ff   <= rd_i && is_cap_byte(addr_i);
        rd_other_ff <= rd_i && !is_cap_byte(addr_i);
        other_ff    <= `TCC_RST_BYTE;
        if (addr_i == `TCC_OFS_CAP3_CTL)
            other_ff <= {capture_three_noise_filter_ff, 5'h00, capture_three_edge_select_ff};
        else if (is_cmp(addr_i))
            other_ff <= {1'b0, rev_ff[addr_i[1:0]], act_ff[addr_i[1:0]], 2'h0,
                         compare_double_buffer_enable_o[addr_i[1:0]], compare_channel_enable_o[addr_i[1:0]]};
    end
end

always @*
begin
    rdata_o = rd_cap_ff ? cap_byte : (rd_other_ff ? other_ff : `TCC_RST_BYTE);
end

endmodule

/* dv/tcc_pin_model.sv */
/*
 trigger pin model for the capture input.
 assumes widths are counted in core clock cycles.
*/
`timescale 1ns/100ps
module tcc_pin_model
(
    input  wire core_clk_i,
    output reg  pin_o
);
    initial pin_o = 1'b0;
    // level changes just after an edge and stands n whole cycles
    task hold(input reg lvl, input integer n);
        begin
            @(posedge core_clk_i);
            pin_o <= lvl;
            repeat (n - 1) @(posedge core_clk_i);
        end
    endtask
endmodule

/* dv/tcc_capture3_compare_asserts.sv */
/*
 port checker for the capture-3 and compare-control block.
 assumes the byte register port of tcc_map.vh.
*/
`timescale 1ns/100ps
`include "tcc_map.vh"
module tcc_chk
#(
    parameter NCH = 4
)
(
    input wire           core_clk_i,
    input wire           rstn_i,
    input wire [7:0]     addr_i,
    input wire [7:0]     wdata_i,
    input wire           wr_i,
    input wire           rd_i,
    input wire [7:0]     rdata_o,
    input wire [NCH-1:0] compare_match_i,
    input wire [NCH-1:0] timer_output_flipflop_o,
    input wire [NCH-1:0] compare_channel_enable_o,
    input wire [NCH-1:0] compare_double_buffer_enable_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_CAP_CTL: assert property (rd_i && addr_i == `TCC_OFS_CAP3_CTL |=> rdata_o[6:2] == 5'h00)
        else $error("capture control reserved bits set");
    AST_CMP_CTL: assert property (rd_i && addr_i[7:2] == 6'h1c |=> !rdata_o[7] && rdata_o[3:2] == 2'h0)
        else $error("compare control reserved bits set");
    AST_EN_WR: assert property (wr_i && addr_i[7:2] == 6'h1c
        |=> compare_channel_enable_o[$past(addr_i[1:0])] == $past(wdata_i[0]))
        else $error("compare enable not written");
    AST_DB_WR: assert property (wr_i && addr_i[7:2] == 6'h1c
        |=> compare_double_buffer_enable_o[$past(addr_i[1:0])] == $past(wdata_i[1]))
        else $error("double buffer enable not written");
    AST_FF_IDLE: assert property (compare_match_i == 4'h0 |=> $stable(timer_output_flipflop_o))
        else $error("flip-flop moved without a match");
    AST_FF_OFF: assert property (!compare_channel_enable_o[0]
        |=> timer_output_flipflop_o[0] == $past(timer_output_flipflop_o[0]))
        else $error("disabled channel flip-flop moved");
    cover property (rd_i && addr_i == `TCC_OFS_CAP3_B3);
    cover property (|(compare_match_i & compare_channel_enable_o));
    cover property (wr_i ##1 rd_i);
endmodule
bind tcc_capture3_compare tcc_chk #(.NCH(NCH)) u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .compare_match_i(compare_match_i), .timer_output_flipflop_o(timer_output_flipflop_o),
    .compare_channel_enable_o(compare_channel_enable_o),
    .compare_double_buffer_enable_o(compare_double_buffer_enable_o));

/* dv/tcc_capture3_compare_tb_top.sv */
/*
 self-checking bench: register reads queued and checked by a monitor.
 assumes the checker is bound by its own file.
*/
`timescale 1ns/100ps
module tcc_capture3_compare_tb_top;
    reg         core_clk_i, rstn_i, wr_i, rd_i, rd_seen;
    reg  [7:0]  addr_i, wdata_i, w;
    reg  [31:0] counter_i, a, b, c, d;
    reg  [3:0]  compare_match_i, eff;
    wire        pin;
    wire [7:0]  rdata_o;
    wire [3:0]  tff, cen, cdb;
    reg  [7:0]  exp_q[$];
    integer     seed, n_mismatch, checked, i, k;
    tcc_pin_model u_pin (.core_clk_i(core_clk_i), .pin_o(pin));
    tcc_capture3_compare DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .capture_three_trigger_pin_i(pin), .counter_i(counter_i),
        .compare_match_i(compare_match_i), .timer_output_flipflop_o(tff),
        .compare_channel_enable_o(cen), .compare_double_buffer_enable_o(cdb));
    always #2 core_clk_i = ~core_clk_i;
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] ad, input [7:0] dt);
        begin
            @(posedge core_clk_i);
            wr_i <= 1'b1; addr_i <= ad; wdata_i <= dt;
            @(posedge core_clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] ad, input [7:0] ex);
        begin
            @(posedge core_clk_i);
            rd_i <= 1'b1; addr_i <= ad; exp_q.push_back(ex);
            @(posedge core_clk_i);
            rd_i <= 1'b0;
        end
    endtask
    task rd32(input [31:0] v);
        for (k = 0; k < 4; k = k + 1) rd(8'h2c + k, v[8*k +: 8]);
    endtask
    // counter holds x while high, y from one cycle before the fall
    task trig(input integer wd, input [31:0] x, input [31:0] y);
        begin
            counter_i <= x; u_pin.hold(1'b1, wd);
            counter_i <= y; u_pin.hold(1'b0, 12);
        end
    endtask
    task wrap_up;
        begin
            $display("checked %0d n_mismatch %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge core_clk_i) rd_seen <= rd_i;
    always @(negedge core_clk_i) if (rd_seen) chk(rdata_o, exp_q.pop_front());
    initial begin #200000; n_mismatch = n_mismatch + 1; wrap_up; end
    initial
    begin
        core_clk_i = 0; rstn_i = 0; wr_i = 0; rd_i = 0; rd_seen = 0; addr_i = 0; wdata_i = 0;
        counter_i = 0; compare_match_i = 0; eff = 0; n_mismatch = 0; checked = 0; seed = 32'h603d874e;
        repeat (6) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        for (i = 0; i < 4; i = i + 1) rd(8'h70 + i, 8'h30);
        rd(8'h28, 8'h00);
        w = $random(seed); wr(8'h28, w); rd(8'h28, w & 8'h83);
        rd(8'h00, 8'h00);
        a = $random(seed); b = $random(seed); c = $random(seed); d = $random(seed);
        wr(8'h28, 8'h01); trig(12, a, b); rd32(a);
        wr(8'h2c, 8'hff); wr(8'h28, 8'h00); trig(12, c, d); rd32(a);
        wr(8'h28, 8'h02); trig(12, a, b); rd32(b);
        wr(8'h28, 8'h03); trig(12, c, d); rd32(d);
        wr(8'h28, 8'h81); trig(4, a, a); rd32(d);
        trig(12, a, b); rd32(a);
        wr(8'h28, 8'h01); trig(3, c, c); rd32(c);
        for (i = 0; i < 24; i = i + 1)
        begin
            k = i % 4;
            w = (i < 16) ? (8'h41 | (($random(seed) & 1) << 1) | ((i / 4) << 4)) : ($random(seed) & 8'h73);
            wr(8'h70 + k, w); rd(8'h70 + k, w);
            if (w[0] && w[6])
                case (w[5:4])
                    2'h0: eff[k] = ~eff[k];
                    2'h1: eff[k] = 1'b1;
                    2'h2: eff[k] = 1'b0;
                    default: ;
                endcase
            @(posedge core_clk_i);
            compare_match_i <= 4'h1 << k; counter_i <= $random(seed);
            @(posedge core_clk_i);
            compare_match_i <= 4'h0;
            @(negedge core_clk_i);
            chk({4'h0, tff}, {4'h0, eff});
        end
        repeat (4) @(posedge core_clk_i);
        wrap_up;
    end
endmodule
